// file: rtl/ccp_pwm.sv
// Overview of operation
// - PWM waveform on the output pin with up to 10-bit duty resolution.
// - Time base chosen independently from one of three 8-bit auto-reload timers.
// - Period is (period register + 1) times four clocks times prescale.
// - After timer equals period: clear timer, set pin unless duty zero, latch duty.
// - Right alignment: duty[9:8] from high byte [1:0], duty[7:0] from low byte.
// - Left alignment: duty[1:0] from low byte [7:6], duty[9:2] from high byte.
// - Duty bytes writable anytime; new duty takes effect only at period end.
// - Time base appends clock phase bits at 1:1 prescale, pre[0] and phase[1] at 1:2, else prescaler bits.
// - Pin clears when the 10-bit time base equals the latched duty.
// - Duty above period leaves the pin unchanged through the period.
// - Resolution is log2(4*(period+1)), full ten bits only at period 255.
// - Timer postscaler has no effect on PWM period or frequency.
// - Reset restores register defaults and puts the pin in input direction.
// - PWM signal is routed internally to other peripherals.
// - Writing zero to the control register releases the output pin.
// - Mode field with both upper bits set selects PWM operation.
// - Timer source codes 00, 01, 10 select timers one to three; 11 reserved.
`timescale 1ns/1ps
module ccp_pwm (
	// Clock and reset
	input  wire logic                              clk_sys,
	input  wire logic                              rst,
	// AHB-Lite slave
	input  wire logic                              hsel,
	input  wire logic [ccp_pwm_pkg::BUS_W-1:0]     haddr,
	input  wire logic [1:0]                        htrans,
	input  wire logic                              hwrite,
	input  wire logic [2:0]                        hsize,
	input  wire logic [ccp_pwm_pkg::BUS_W-1:0]     hwdata,
	input  wire logic                              hready,
	output logic                                   hreadyout,
	output logic                                   hresp,
	output logic      [ccp_pwm_pkg::BUS_W-1:0]     hrdata,
	// Output pin toward the load
	output logic                                   pinOut,
	output logic                                   pinOe,
	// Internal PWM signal for other peripherals
	output logic                                   pwmSignal
);
	import ccp_pwm_pkg::*;

	typedef struct packed {
		logic [7:0]                  control;
		logic [7:0]                  dutyLow;
		logic [7:0]                  dutyHigh;
		logic [1:0]                  timerSel;
		logic                        pinDir;
		logic [NUM_TIMERS-1:0]       matchFlags;
		logic [NUM_TIMERS-1:0][7:0]  timerCon;
		logic [NUM_TIMERS-1:0][7:0]  timerPeriod;
		logic [9:0]                  dutyLatch;
		logic                        pwm;
		logic                        pinOut;
		logic                        pinOe;
		logic [1:0]                  phase;
		logic [ADDR_W-1:0]           addr;
		logic                        wrPend;
		logic                        rdPend;
		logic                        ready;
		logic [BUS_W-1:0]            rdata;
	} ccp_state_t;

	ccp_state_t                  st_ff;
	ccp_state_t                  nxt_st;
	logic [NUM_TIMERS-1:0][7:0]  tmrCount;
	logic [NUM_TIMERS-1:0][1:0]  tmrSub;
	logic [NUM_TIMERS-1:0]       tmrEnd;
	logic                        accept;
	logic                        pwmMode;
	logic                        selValid;
	logic                        selEnd;
	logic [9:0]                  selBase;
	logic [9:0]                  dutyWord;
	logic [7:0]                  wrByte;
	logic [7:0]                  tmrAddr;
	logic [BUS_W-1:0]            readVal;

	genvar g;
	generate
		for (g = 0; g < NUM_TIMERS; g++)
		begin : gen_timer
			// Postscaler bits are never passed on
			pwm_timebase u_timebase (
				.clk_sys   (clk_sys),
				.rst       (rst),
				.phase     (st_ff.phase),
				.timerOn   (st_ff.timerCon[g][TCON_ON]),
				.prescale  (st_ff.timerCon[g][TCON_PRESCALE+:3]),
				.period    (st_ff.timerPeriod[g]),
				.count     (tmrCount[g]),
				.subBits   (tmrSub[g]),
				.periodEnd (tmrEnd[g])
			);
		end
	endgenerate

	always_comb
	begin
		nxt_st = st_ff;
		wrByte = hwdata[7:0];
		tmrAddr = 8'h00;
		readVal = '0;
		nxt_st.phase = st_ff.phase + 2'd1;

		// Register write, data phase of an accepted write
		if (st_ff.wrPend)
		begin
			case (st_ff.addr)
				OFF_CONTROL:   nxt_st.control = wrByte & ~(8'h01 << CTL_OUT);
				OFF_DUTY_LOW:  nxt_st.dutyLow = wrByte;
				OFF_DUTY_HIGH: nxt_st.dutyHigh = wrByte;
				OFF_TSEL:      nxt_st.timerSel = wrByte[1:0];
				OFF_PIN_DIR:   nxt_st.pinDir = wrByte[0];
				OFF_FLAGS:     nxt_st.matchFlags = st_ff.matchFlags & ~wrByte[NUM_TIMERS-1:0];
				default:       nxt_st.control = st_ff.control;
			endcase
			for (int i = 0; i < NUM_TIMERS; i++)
			begin
				tmrAddr = 8'(OFF_TMR_BASE + i * OFF_TMR_STEP);
				if (st_ff.addr == tmrAddr + OFF_TMR_CON)
					nxt_st.timerCon[i] = wrByte;
				if (st_ff.addr == tmrAddr + OFF_TMR_PER)
					nxt_st.timerPeriod[i] = wrByte;
			end
		end

		// A period end sets its flag even in the cycle software clears it
		for (int i = 0; i < NUM_TIMERS; i++)
		begin
			if (tmrEnd[i])
				nxt_st.matchFlags[i] = 1'b1;
		end

		// Read mux; bits above the register width read as zero
		case (st_ff.addr)
			OFF_CONTROL:
			begin
				readVal[7:0] = st_ff.control;
				readVal[CTL_OUT] = st_ff.pwm;
			end
			OFF_DUTY_LOW:  readVal[7:0] = st_ff.dutyLow;
			OFF_DUTY_HIGH: readVal[7:0] = st_ff.dutyHigh;
			OFF_TSEL:      readVal[1:0] = st_ff.timerSel;
			OFF_PIN_DIR:   readVal[0] = st_ff.pinDir;
			OFF_FLAGS:     readVal[NUM_TIMERS-1:0] = st_ff.matchFlags;
			default:       readVal = '0;
		endcase
		for (int i = 0; i < NUM_TIMERS; i++)
		begin
			tmrAddr = 8'(OFF_TMR_BASE + i * OFF_TMR_STEP);
			if (st_ff.addr == tmrAddr + OFF_TMR_CON)
				readVal[7:0] = st_ff.timerCon[i];
			if (st_ff.addr == tmrAddr + OFF_TMR_PER)
				readVal[7:0] = st_ff.timerPeriod[i];
			if (st_ff.addr == tmrAddr + OFF_TMR_CNT)
				readVal[7:0] = tmrCount[i];
		end

		// Bus handshake: reads take one wait state so that a write just
		// before them is already visible
		accept = hsel && hready && htrans[1];
		nxt_st.wrPend = accept && hwrite;
		nxt_st.rdPend = accept && !hwrite;
		if (accept)
			nxt_st.addr = haddr[ADDR_W-1:0];
		nxt_st.ready = !(accept && !hwrite);
		if (st_ff.rdPend)
			nxt_st.rdata = readVal;

		// Time base selection
		selValid = st_ff.timerSel != TSEL_NONE;
		selEnd = 1'b0;
		selBase = 10'h000;
		for (int i = 0; i < NUM_TIMERS; i++)
		begin
			if (selValid && st_ff.timerSel == 2'(i))
			begin
				selEnd = tmrEnd[i];
				selBase = {tmrCount[i], tmrSub[i]};
			end
		end

		// Duty alignment in the register pair
		if (st_ff.control[CTL_ALIGN])
			dutyWord = {st_ff.dutyHigh, st_ff.dutyLow[7:6]};
		else
			dutyWord = {st_ff.dutyHigh[1:0], st_ff.dutyLow};

		// Waveform; period length and resolution follow from the timer
		pwmMode = st_ff.control[CTL_EN]
			&& st_ff.control[CTL_MODE+2+:2] == MODE_PWM_TOP;
		if (!pwmMode)
		begin
			nxt_st.pwm = 1'b0;
		end
		else if (selEnd)
		begin
			nxt_st.dutyLatch = dutyWord;
			nxt_st.pwm = dutyWord != 10'h000;
		end
		else if (selBase == st_ff.dutyLatch)
		begin
			// A latched duty beyond the period never matches, so the pin holds
			nxt_st.pwm = 1'b0;
		end

		// Pin drive; a cleared control register drops the enable
		nxt_st.pinOut = nxt_st.pwm;
		nxt_st.pinOe = pwmMode && st_ff.control[CTL_OE] && !st_ff.pinDir;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			st_ff <= '0;
			st_ff.control <= RST_CONTROL;
			st_ff.dutyLow <= RST_DUTY;
			st_ff.dutyHigh <= RST_DUTY;
			st_ff.timerSel <= RST_TSEL;
			st_ff.pinDir <= RST_PIN_DIR;
			st_ff.timerCon <= {NUM_TIMERS{RST_TCON}};
			st_ff.timerPeriod <= {NUM_TIMERS{RST_PERIOD}};
			st_ff.ready <= 1'b1;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign hreadyout = st_ff.ready;
	assign hresp     = 1'b0;
	assign hrdata    = st_ff.rdata;
	assign pinOut    = st_ff.pinOut;
	assign pinOe     = st_ff.pinOe;
	assign pwmSignal = st_ff.pwm;

endmodule

// file: rtl/pwm_timebase.sv
`timescale 1ns/1ps
module pwm_timebase (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// Instruction clock phase
	input  wire logic [1:0] phase,
	// Timer configuration
	input  wire logic       timerOn,
	input  wire logic [2:0] prescale,
	input  wire logic [7:0] period,
	// Time base
	output logic      [7:0] count,
	output logic      [1:0] subBits,
	output logic            periodEnd
);
	import ccp_pwm_pkg::*;

	timer_state_t st_ff;
	timer_state_t nxt_st;
	logic [6:0]   preMask;
	logic [6:0]   preShift;

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.periodEnd = 1'b0;
		preMask = 7'((8'h01 << prescale) - 8'h01);
		if (!timerOn)
		begin
			nxt_st.pre = 7'h00;
		end
		else if (phase == PHASE_LAST)
		begin
			if ((st_ff.pre & preMask) == preMask)
			begin
				nxt_st.pre = 7'h00;
				if (st_ff.count == period)
				begin
					// Match ends the period on the following increment
					nxt_st.count = 8'h00;
					nxt_st.periodEnd = 1'b1;
				end
				else
				begin
					nxt_st.count = st_ff.count + 8'h01;
				end
			end
			else
			begin
				nxt_st.pre = st_ff.pre + 7'h01;
			end
		end
		// Two sub-count bits extend the 8-bit count to ten bits
		preShift = st_ff.pre >> (prescale - 3'd2);
		case (prescale)
			3'd0: subBits = phase;
			3'd1: subBits = {st_ff.pre[0], phase[1]};
			default: subBits = preShift[1:0];
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign count     = st_ff.count;
	assign periodEnd = st_ff.periodEnd;

endmodule

// file: shared/ccp_pwm_pkg.sv
package ccp_pwm_pkg;

	// Bus geometry
	localparam int BUS_W  = 32;
	localparam int ADDR_W = 8;

	// Register byte offsets
	localparam logic [7:0] OFF_CONTROL   = 8'h00;
	localparam logic [7:0] OFF_DUTY_LOW  = 8'h04;
	localparam logic [7:0] OFF_DUTY_HIGH = 8'h08;
	localparam logic [7:0] OFF_TSEL      = 8'h0c;
	localparam logic [7:0] OFF_PIN_DIR   = 8'h10;
	localparam logic [7:0] OFF_FLAGS     = 8'h14;
	localparam logic [7:0] OFF_TMR_BASE  = 8'h20;
	localparam logic [7:0] OFF_TMR_STEP  = 8'h10;
	localparam logic [7:0] OFF_TMR_CON   = 8'h00;
	localparam logic [7:0] OFF_TMR_PER   = 8'h04;
	localparam logic [7:0] OFF_TMR_CNT   = 8'h08;

	// Control register fields
	localparam int CTL_EN   = 7;
	localparam int CTL_OE   = 6;
	localparam int CTL_OUT  = 5;
	localparam int CTL_ALIGN = 4;
	localparam int CTL_MODE = 0;
	localparam logic [1:0] MODE_PWM_TOP = 2'b11;

	// Timer control fields
	localparam int TCON_ON   = 7;
	localparam int TCON_PRESCALE = 4;

	// Timer source codes
	localparam logic [1:0] TSEL_NONE = 2'b11;

	// Reset values
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_DUTY    = 8'h00;
	localparam logic [1:0] RST_TSEL    = 2'b00;
	localparam logic       RST_PIN_DIR = 1'b1;
	localparam logic [7:0] RST_TCON    = 8'h00;
	localparam logic [7:0] RST_PERIOD  = 8'hff;

	// Timers run from the instruction clock, one tick every INSTR_DIV system clocks
	localparam int         INSTR_DIV   = 4;
	localparam logic [1:0] PHASE_LAST  = 2'(INSTR_DIV - 1);
	localparam int         NUM_TIMERS  = 3;

	typedef struct packed {
		logic [6:0] pre;
		logic [7:0] count;
		logic       periodEnd;
	} timer_state_t;

endpackage

// file: tb/capture_compare_unit_pwm_mode_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module capture_compare_unit_pwm_mode_tb;
	import ccp_pwm_pkg::*;
	logic			clk_sys = 0, rst = 1, hsel = 0, hwrite = 0;
	logic [BUS_W-1:0]	haddr = '0, hwdata = '0, hrdata;
	logic [1:0]		htrans = '0;
	logic			hreadyout, hresp, pinOut, pinOe, pwmSignal, pinLevel;
	int			miscompares = 0, comparisons = 0, cycles = 0, lastHigh, lastPer;
	logic [7:0]		ctlT [4] = '{8'hcc, 8'hcf, 8'hcb, 8'h00};
	int			dutyT [4] = '{0, 20, 20, 20}, highT [4] = '{0, 64, 0, 0};
	logic			oeT [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
	always #25 clk_sys = ~clk_sys;
	ccp_pwm dut_u (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pinOut(pinOut),
		.pinOe(pinOe), .pwmSignal(pwmSignal));
	pwm_load load_u (.clk_sys(clk_sys), .rst(rst), .pinOut(pinOut), .pinOe(pinOe),
		.pinLevel(pinLevel), .lastHigh(lastHigh), .lastPer(lastPer));
	task automatic tally_and_finish();
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk_sys)
		if (++cycles == 20000)
		begin
			miscompares++;
			tally_and_finish();
		end
	function automatic logic [7:0] tAddr(int i, logic [7:0] off);
		return 8'(OFF_TMR_BASE + OFF_TMR_STEP * 8'(i) + off);
	endfunction
	// Holds the address phase until the slave takes it
	task automatic busAddr(input logic [7:0] a, input logic w);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
	endtask
	task automatic busWr(input logic [7:0] a, input logic [7:0] d);
		busAddr(a, 1'b1);
		hwdata <= {24'h0, d};
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
	endtask
	task automatic busRd(input logic [7:0] a, output logic [7:0] v);
		busAddr(a, 1'b0);
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		v = hrdata[7:0];
	endtask
	task automatic chkRd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		busRd(a, v);
		`CHK(v, e)
	endtask
	task automatic chkReset();
		logic [7:0] ra [$];
		logic [7:0] rv [$];
		ra = '{OFF_CONTROL, OFF_DUTY_LOW, OFF_DUTY_HIGH, OFF_TSEL, OFF_PIN_DIR, OFF_FLAGS};
		rv = '{RST_CONTROL, RST_DUTY, RST_DUTY, 8'(RST_TSEL), 8'(RST_PIN_DIR), 8'h00};
		for (int i = 0; i < NUM_TIMERS; i++)
		begin
			ra = {ra, tAddr(i, OFF_TMR_CON), tAddr(i, OFF_TMR_PER), tAddr(i, OFF_TMR_CNT)};
			rv = {rv, RST_TCON, RST_PERIOD, 8'h00};
		end
		`CHK(pinOe, 1'b0)
		foreach (ra[k])
			chkRd(ra[k], rv[k]);
	endtask
	// Follows the recommended start-up order, then measures the settled waveform
	task automatic runPwm(int sel, int n, logic fmt);
		int per, d;
		logic [7:0] hi, lo, v;
		per = 2 + $urandom % 8;
		d = 1 + $urandom % (4 * (per + 1) - 1);
		hi = fmt ? 8'(d >> 2) : {6'($urandom), 2'(d >> 8)};
		lo = fmt ? {2'(d), 6'($urandom)} : 8'(d);
		busWr(OFF_PIN_DIR, 8'h01);
		busWr(OFF_TSEL, 8'(sel));
		busWr(tAddr(sel, OFF_TMR_PER), 8'(per));
		busWr(OFF_CONTROL, {3'b110, fmt, 2'b11, 2'($urandom)});
		busWr(OFF_DUTY_HIGH, hi);
		busWr(OFF_DUTY_LOW, lo);
		busWr(OFF_FLAGS, 8'h07);
		busWr(tAddr(sel, OFF_TMR_CON), {1'b1, 3'(n), 4'($urandom)});
		do busRd(OFF_FLAGS, v); while (v[sel] !== 1'b1);
		busWr(OFF_PIN_DIR, 8'h00);
		repeat (3 * (per + 1) * (4 << n) + 8) @(posedge clk_sys);
		`CHK(lastPer, (per + 1) * (4 << n))
		`CHK(lastHigh, d << n)
		chkRd(OFF_DUTY_LOW, lo);
		busWr(tAddr(sel, OFF_TMR_CON), 8'h00);
	endtask
	initial
	begin
		int highs;
		void'($urandom(51641));
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		chkReset();
		busWr(8'hfc, 8'hff);
		chkRd(8'hfc, 8'h00);
		for (int i = 0; i < NUM_TIMERS; i++)
			runPwm(i, i, 1'(i));
		busWr(OFF_TSEL, 8'h00);
		busWr(tAddr(0, OFF_TMR_PER), 8'h03);
		busWr(tAddr(0, OFF_TMR_CON), 8'h80);
		for (int k = 0; k < 4; k++)
		begin
			busWr(OFF_CONTROL, ctlT[k]);
			busWr(OFF_DUTY_HIGH, 8'h00);
			busWr(OFF_DUTY_LOW, 8'(dutyT[k]));
			// Timer 0 may hold a count above its new period and must wrap first
			repeat (k == 0 ? 1100 : 40) @(posedge clk_sys);
			highs = 0;
			repeat (64) @(posedge clk_sys) highs += (pwmSignal === 1'b1);
			`CHK(highs, highT[k])
			`CHK(pinOe, oeT[k])
		end
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		chkReset();
		tally_and_finish();
	end
endmodule
bind ccp_pwm ccp_pwm_chk chk_u (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .pinOut(pinOut), .pwmSignal(pwmSignal));

// file: tb/ccp_pwm_chk.sv
`timescale 1ns/1ps
module ccp_pwm_chk (
	// Clock and reset
	input wire logic				clk_sys,
	input wire logic				rst,
	// Bus
	input wire logic				hsel,
	input wire logic [1:0]				htrans,
	input wire logic				hwrite,
	input wire logic				hready,
	input wire logic				hreadyout,
	input wire logic				hresp,
	input wire logic [ccp_pwm_pkg::BUS_W-1:0]	hrdata,
	// PWM
	input wire logic				pinOut,
	input wire logic				pwmSignal
);
	logic		rdTaken;
	logic		wrTaken;
	logic		seenRise_ff;
	logic [11:0]	sinceRise_ff;
	assign rdTaken = hsel && hready && htrans[1] && !hwrite;
	assign wrTaken = hsel && hready && htrans[1] && hwrite;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Counter wraps at a multiple of four, so its low bits stay meaningful
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			sinceRise_ff <= 12'h000;
			seenRise_ff <= 1'b0;
		end
		else
		begin
			sinceRise_ff <= $rose(pwmSignal) ? 12'h000 : sinceRise_ff + 12'h001;
			seenRise_ff <= seenRise_ff | $rose(pwmSignal);
		end
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	a_write_nowait: assert property (wrTaken |=> hreadyout)
		else $error("write stalled");
	a_read_wait: assert property (rdTaken |=> !hreadyout ##1 hreadyout)
		else $error("read wait not one cycle");
	a_wait_cause: assert property (!hreadyout |-> $past(rdTaken))
		else $error("stall without read");
	a_rdata_upper: assert property ($rose(hreadyout) |-> hrdata[ccp_pwm_pkg::BUS_W-1:8] == '0)
		else $error("read data upper bits set");
	a_pin_follows: assert property (pinOut == pwmSignal)
		else $error("pin and internal signal differ");
	a_rise_space: assert property ($rose(pwmSignal) |=> !$rose(pwmSignal) [*3])
		else $error("period shorter than four clocks");
	a_rise_grid: assert property ($rose(pwmSignal) && seenRise_ff |-> sinceRise_ff[1:0] == 2'h3)
		else $error("period not a multiple of four clocks");
endmodule

// file: tb/pwm_load.sv
`timescale 1ns/1ps
module pwm_load (
	// Clock and reset
	input wire logic	clk_sys,
	input wire logic	rst,
	// Pin
	input wire logic	pinOut,
	input wire logic	pinOe,
	// Measurements
	output logic		pinLevel,
	output int		lastHigh,
	output int		lastPer
);
	int	cyc = 0;
	int	riseAt = 0;
	logic	drvLast = 1'b0;
	logic	prev = 1'b0;
	// Undriven pin floats: show the opposite of the last driven level
	assign pinLevel = pinOe ? pinOut : ~drvLast;
	always @(posedge clk_sys)
	begin
		cyc++;
		if (pinOe)
			drvLast <= pinOut;
		prev <= pinLevel;
		if (pinLevel && !prev)
		begin
			lastPer <= cyc - riseAt;
			riseAt <= cyc;
		end
		if (!pinLevel && prev)
			lastHigh <= cyc - riseAt;
	end
endmodule
